//--- common/uart_mls_pkg.sv
package uart_mls_pkg;

   // Register byte offsets on the bus, one aligned word each
   localparam logic [31:0] OFS_HOLDING = 32'h0000_0000;
   localparam logic [31:0] OFS_INT_ENABLE = 32'h0000_0004;
   localparam logic [31:0] OFS_MODEM_CONTROL = 32'h0000_0008;
   localparam logic [31:0] OFS_LINE_STATUS = 32'h0000_000C;
   localparam logic [31:0] OFS_MODEM_STATUS = 32'h0000_0010;
   localparam logic [31:0] OFS_SCRATCH_PAD = 32'h0000_0014;
   localparam logic [31:0] OFS_ALT_FUNCTION = 32'h0000_0018;
   localparam logic [31:0] OFS_FEATURE_CONTROL = 32'h0000_001C;
   localparam logic [31:0] OFS_ENH_FEATURE = 32'h0000_0020;
   localparam logic [31:0] OFS_XON_CHAR = 32'h0000_0024;
   localparam logic [31:0] OFS_XOFF_CHAR = 32'h0000_0028;

   // Modem control fields
   localparam int MC_DTR = 0;
   localparam int MC_RTS = 1;
   localparam int MC_AUX1 = 2;
   localparam int MC_AUX2 = 3;
   localparam int MC_LOOP = 4;
   localparam int MC_XON_ANY = 5;
   localparam int MC_IR_EN = 6;
   localparam int MC_PRESCALE = 7;

   // Other control fields
   localparam int IE_MODEM = 3;
   localparam int EF_AUTO_RTS = 6;
   localparam int EF_AUTO_CTS = 7;
   localparam int FC_IR_RX_HIGH = 2;
   localparam int FC_SWAP = 6;

   // Reset values
   localparam logic [7:0] SCRATCH_RESET = 8'hFF;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Receive store and flow control
   localparam int RX_DEPTH = 16;
   localparam logic [4:0] RX_DEPTH_CNT = 5'h10;
   localparam logic [4:0] RTS_HALT_LEVEL = 5'h0C;

   // Prescaler count in clock cycles; infrared timing in sixteenth-bit ticks
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
   localparam logic [3:0] IR_BIT_LAST = 4'hF;

   // Alternate function select codes for the multifunction pin
   localparam logic [1:0] MF_AUX2 = 2'h0;
   localparam logic [1:0] MF_BAUD = 2'h1;
   localparam logic [1:0] MF_RX_READY = 2'h2;

   // Counter mode codes for the swapped scratch location
   localparam logic [1:0] CNT_TX = 2'h1;
   localparam logic [1:0] CNT_ALT = 2'h3;

   // Received character with its error marks
   typedef struct packed {
      logic [7:0] data;
      logic parity_err;
      logic framing_err;
      logic brk;
   } rx_char_t;

   // Modem inputs, all active low pins
   typedef struct packed {
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } modem_in_t;

   // Modem outputs, all active low pins
   typedef struct packed {
      logic rts_n;
      logic dtr_n;
      logic multifunction_pin_n;
   } modem_out_t;

endpackage : uart_mls_pkg

//--- hdl/uart_modem_line_status.sv
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
// Behaviour
// RQ1 - RTS bit set drives its pin low, clear (reset) high.
// RQ2 - Auto receive flow control drives the RTS pin when enabled.
// RQ3 - Aux one has no pin; in loopback it reads as ring.
// RQ4 - Aux two drives multifunction pin low when set; loopback: carrier detect.
// RQ5 - Loopback bit selects local loopback; normal after reset.
// RQ6 - Xon-any resumes transmit on any character; flow characters not stored.
// RQ7 - Infrared bit routes data via encoder and decoder; transmit idles low.
// RQ8 - Prescaler bit divides the baud clock by four.
// RQ9 - Data ready while any received character is held.
// RQ10 - Character at full store sets overrun and is dropped.
// RQ11 - Parity error follows the head character.
// RQ12 - Framing error follows the head character.
// RQ13 - One break character stored; indication held until line marks.
// RQ14 - Holding empty sets on transfer to shifter, clears on load.
// RQ15 - Transmitter empty when holding and shifter both empty.
// RQ16 - Store error flag while any stored character has an error.
// RQ17 - Delta bits set on CTS, DSR, CD change; interrupt if enabled.
// RQ18 - Ring delta only at end of ringing.
// RQ19 - Auto CTS: high input halts after current character, low resumes.
// RQ20 - Upper status bits: inverted pins, or control bits in loopback.
// RQ21 - Scratch register holds host value; all ones after reset.
// RQ22 - Swap bit set sends scratch writes to enhanced mode select.
// RQ23 - DTR bit set drives its pin low, clear (reset) high.
// RQ24 - Modem status read clears the four delta bits.
// RQ25 - Loopback feeds transmit to receive; pins idle and inactive.
module uart_modem_line_status (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Receiver engine side
   input wire logic rx_valid,
   input wire uart_mls_pkg::rx_char_t rx_char,
   output logic rx_serial,
   // Transmitter engine side
   input wire logic tx_shift_busy,
   input wire logic tx_serial_bit,
   output logic tx_load,
   output logic [7:0] tx_byte,
   // Baud generator side
   input wire logic baud16_tick,
   output logic baud_src_tick,
   // Serial and modem pins
   input wire logic ser_rx_pin,
   output logic ser_tx_pin,
   input wire uart_mls_pkg::modem_in_t modem_in,
   output uart_mls_pkg::modem_out_t modem_out,
   // Modem status request
   output logic modem_irq
);

   typedef struct packed {
      logic ready;
      logic resp;
      logic [31:0] rdata;
      logic pend;
      logic pend_write;
      logic [31:0] pend_addr;
      logic [7:0] modem_control;
      logic [7:0] int_enable;
      logic [7:0] alternate_function;
      logic [7:0] feature_control;
      logic [7:0] enhanced_feature_control;
      logic [7:0] xon_char;
      logic [7:0] xoff_char;
      logic [7:0] scratch_pad;
      logic [7:0] enhanced_mode_select;
      logic alt_tx;
      logic [7:0] holding;
      logic holding_empty;
      logic tx_load;
      logic [7:0] tx_byte;
      logic sw_halt;
      logic [uart_mls_pkg::RX_DEPTH-1:0][10:0] mem;
      logic [3:0] wr_ptr;
      logic [3:0] rd_ptr;
      logic [4:0] count;
      logic [4:0] err_cnt;
      logic overrun;
      logic brk_hold;
      logic [3:0] level;
      logic [3:0] delta;
      logic irq;
      logic [1:0] div;
      logic baud_tick;
      logic [3:0] ir_tx_cnt;
      logic ir_prev_bit;
      logic [3:0] ir_rx_cnt;
      logic tx_pin;
      logic rx_serial;
      uart_mls_pkg::modem_out_t mout;
   } state_t;

   state_t s_q;
   state_t s_d;

   // Any of parity, framing or break marks on a stored entry
   function automatic logic has_err(input logic [10:0] entry);
      has_err = |entry[2:0];
   endfunction : has_err

   // Bus address match, shared by read and write decode
   function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // Outputs straight from the state register
   assign hrdata = s_q.rdata;
   assign hreadyout = s_q.ready;
   assign hresp = s_q.resp;
   assign rx_serial = s_q.rx_serial;
   assign tx_load = s_q.tx_load;
   assign tx_byte = s_q.tx_byte;
   assign baud_src_tick = s_q.baud_tick;
   assign ser_tx_pin = s_q.tx_pin;
   assign modem_out = s_q.mout;
   assign modem_irq = s_q.irq;

   // Next state: bus, receive store, transmit, modem and pins
   always_comb begin
      logic loop;
      logic [3:0] lvl;
      logic [3:0] dset;
      logic do_rd;
      logic do_wr;
      logic [7:0] wd;
      logic [7:0] rd_val;
      logic [7:0] line_status;
      logic [7:0] modem_status;
      logic [7:0] flvl;
      logic [10:0] head;
      logic sw_active;
      logic flow_hit;
      logic want_push;
      logic push;
      logic pop;
      logic cts_stop;
      logic ir_pulse;
      logic ir_in;
      logic ir_dec;
      logic dr;
      lvl = 4'h0;
      flvl = 8'h00;
      s_d = s_q;
      s_d.tx_load = 1'b0;
      s_d.resp = 1'b0;
      loop = s_q.modem_control[uart_mls_pkg::MC_LOOP];
      do_rd = s_q.pend & ~s_q.pend_write;
      do_wr = s_q.pend & s_q.pend_write;
      wd = hwdata[7:0];
      head = s_q.mem[s_q.rd_ptr];
      dr = (s_q.count != 5'h00);
      sw_active = (s_q.enhanced_feature_control[3:0] != 4'h0);

      // Modem levels in active-high sense, {cd, ri, dsr, cts}
      if (loop) begin
         lvl = {s_q.modem_control[uart_mls_pkg::MC_AUX2],   // [RQ4] [RQ20]
                s_q.modem_control[uart_mls_pkg::MC_AUX1],   // [RQ3] [RQ20]
                s_q.modem_control[uart_mls_pkg::MC_DTR],
                s_q.modem_control[uart_mls_pkg::MC_RTS]};
      end else begin
         lvl = ~{modem_in.cd_n, modem_in.ri_n, modem_in.dsr_n, modem_in.cts_n}; // [RQ20]
      end

      // Status images built from held state and the shifter busy input
      line_status = {s_q.err_cnt != 5'h00, // [RQ16]
             s_q.holding_empty & ~tx_shift_busy & ~s_q.tx_load, // [RQ15]
             s_q.holding_empty, // [RQ14]
             dr & head[0], // [RQ13]
             dr & head[1], // [RQ12]
             dr & head[2], // [RQ11]
             s_q.overrun,
             dr}; // [RQ9]
      modem_status = {s_q.level, s_q.delta};
      if (s_q.enhanced_mode_select[1:0] == uart_mls_pkg::CNT_TX ||
          (s_q.enhanced_mode_select[1:0] == uart_mls_pkg::CNT_ALT && s_q.alt_tx)) begin
         flvl = {7'h00, ~s_q.holding_empty};
      end else begin
         flvl = {3'h0, s_q.count};
      end

      // Read mux, unmapped addresses read zero
      if (hit(s_q.pend_addr, uart_mls_pkg::OFS_HOLDING)) begin
         rd_val = dr ? head[10:3] : 8'h00;
      end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_INT_ENABLE)) begin
         rd_val = s_q.int_enable;
      end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_MODEM_CONTROL)) begin
         rd_val = s_q.modem_control;
      end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_LINE_STATUS)) begin
         rd_val = line_status;
      end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_MODEM_STATUS)) begin
         rd_val = modem_status;
      end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_SCRATCH_PAD)) begin
         rd_val = s_q.feature_control[uart_mls_pkg::FC_SWAP] ? flvl : s_q.scratch_pad;
      end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_ALT_FUNCTION)) begin
         rd_val = s_q.alternate_function;
      end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_FEATURE_CONTROL)) begin
         rd_val = s_q.feature_control;
      end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_ENH_FEATURE)) begin
         rd_val = s_q.enhanced_feature_control;
      end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_XON_CHAR)) begin
         rd_val = s_q.xon_char;
      end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_XOFF_CHAR)) begin
         rd_val = s_q.xoff_char;
      end else begin
         rd_val = 8'h00;
      end

      // One wait state per transfer so a write lands before any later read
      if (s_q.pend) begin
         s_d.pend = 1'b0;
         s_d.ready = 1'b1;
         s_d.rdata = do_rd ? {24'h00_0000, rd_val} : 32'h0000_0000;
      end else if (hsel && htrans[1] && hready && s_q.ready) begin
         s_d.pend = 1'b1;
         s_d.ready = 1'b0;
         s_d.pend_write = hwrite;
         s_d.pend_addr = haddr;
      end

      // Register writes in the data phase
      if (do_wr) begin
         if (hit(s_q.pend_addr, uart_mls_pkg::OFS_HOLDING)) begin
            s_d.holding = wd;
         end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_INT_ENABLE)) begin
            s_d.int_enable = wd;
         end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_MODEM_CONTROL)) begin
            s_d.modem_control = wd;
         end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_SCRATCH_PAD)) begin
            if (s_q.feature_control[uart_mls_pkg::FC_SWAP]) begin
               s_d.enhanced_mode_select = wd; // [RQ22]
               s_d.alt_tx = 1'b0;
            end else begin
               s_d.scratch_pad = wd; // [RQ21]
            end
         end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_ALT_FUNCTION)) begin
            s_d.alternate_function = {5'h00, wd[2:0]};
         end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_FEATURE_CONTROL)) begin
            s_d.feature_control = wd;
         end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_ENH_FEATURE)) begin
            s_d.enhanced_feature_control = wd;
         end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_XON_CHAR)) begin
            s_d.xon_char = wd;
         end else if (hit(s_q.pend_addr, uart_mls_pkg::OFS_XOFF_CHAR)) begin
            s_d.xoff_char = wd;
         end
      end

      // Alternate counter mode flips between rx and tx on each read
      if (do_rd && hit(s_q.pend_addr, uart_mls_pkg::OFS_SCRATCH_PAD) &&
          s_q.feature_control[uart_mls_pkg::FC_SWAP] &&
          s_q.enhanced_mode_select[1:0] == uart_mls_pkg::CNT_ALT) begin
         s_d.alt_tx = ~s_q.alt_tx;
      end

      // Receive store: flow characters and repeat breaks are not stored
      flow_hit = sw_active && rx_valid &&
                 (rx_char.data == s_q.xon_char || rx_char.data == s_q.xoff_char); // [RQ6]
      want_push = rx_valid & ~flow_hit & ~(rx_char.brk & s_q.brk_hold); // [RQ13]
      push = want_push && (s_q.count != uart_mls_pkg::RX_DEPTH_CNT); // [RQ10]
      pop = do_rd && hit(s_q.pend_addr, uart_mls_pkg::OFS_HOLDING) && dr;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = {rx_char.data, rx_char.parity_err,
                                rx_char.framing_err, rx_char.brk};
         s_d.wr_ptr = s_q.wr_ptr + 4'h1;
      end
      if (pop) begin
         s_d.rd_ptr = s_q.rd_ptr + 4'h1;
      end
      s_d.count = s_q.count + {4'h0, push} - {4'h0, pop}; // [RQ9]
      s_d.err_cnt = s_q.err_cnt + {4'h0, push & has_err(s_d.mem[s_q.wr_ptr])}
                    - {4'h0, pop & has_err(head)}; // [RQ16]

      // Overrun clears on a status read; a new overrun wins
      if (do_rd && hit(s_q.pend_addr, uart_mls_pkg::OFS_LINE_STATUS)) begin
         s_d.overrun = 1'b0;
      end
      if (want_push && !push) begin
         s_d.overrun = 1'b1;                                  // [RQ10]
      end

      // Break held until the line returns to mark; stored break wins
      if (s_q.rx_serial) begin
         s_d.brk_hold = 1'b0;
      end
      if (push && rx_char.brk) begin
         s_d.brk_hold = 1'b1;                                 // [RQ13]
      end

      // Software flow halt and Xon-any resume
      if (!sw_active) begin
         s_d.sw_halt = 1'b0;
      end
      if (rx_valid && s_q.modem_control[uart_mls_pkg::MC_XON_ANY]) begin
         s_d.sw_halt = 1'b0;                                  // [RQ6]
      end
      if (rx_valid && sw_active) begin
         if (rx_char.data == s_q.xoff_char) begin
            s_d.sw_halt = 1'b1;
         end else if (rx_char.data == s_q.xon_char) begin
            s_d.sw_halt = 1'b0;
         end
      end

      // Transmit hand-off; auto CTS only gates the next character
      cts_stop = s_q.enhanced_feature_control[uart_mls_pkg::EF_AUTO_CTS] & ~lvl[0]; // [RQ19]
      if (!s_q.holding_empty && !tx_shift_busy && !s_q.tx_load &&
          !s_q.sw_halt && !cts_stop) begin
         s_d.tx_load = 1'b1;
         s_d.tx_byte = s_q.holding;
         s_d.holding_empty = 1'b1;                            // [RQ14]
      end
      if (do_wr && hit(s_q.pend_addr, uart_mls_pkg::OFS_HOLDING)) begin
         s_d.holding_empty = 1'b0;                            // [RQ14]
      end

      // Modem deltas: ring only on trailing edge; set wins over read clear
      dset = {(s_q.level[3] ^ lvl[3]), (s_q.level[2] & ~lvl[2]),  // [RQ18]
              (s_q.level[1] ^ lvl[1]), (s_q.level[0] ^ lvl[0])};  // [RQ17]
      if (do_rd && hit(s_q.pend_addr, uart_mls_pkg::OFS_MODEM_STATUS)) begin
         s_d.delta = 4'h0;                                    // [RQ24]
      end
      s_d.delta = s_d.delta | dset;
      s_d.level = lvl;
      s_d.irq = s_q.int_enable[uart_mls_pkg::IE_MODEM] & (|s_d.delta); // [RQ17]

      // Prescaler feeding the baud generator
      s_d.div = s_q.div + 2'h1;
      s_d.baud_tick = ~s_q.modem_control[uart_mls_pkg::MC_PRESCALE] |
                      (s_q.div == uart_mls_pkg::PRESCALE_LAST);   // [RQ8]

      // Infrared encoder: short high pulse for each zero bit
      if (tx_serial_bit != s_q.ir_prev_bit) begin
         s_d.ir_tx_cnt = 4'h0;
      end else if (baud16_tick) begin
         s_d.ir_tx_cnt = s_q.ir_tx_cnt + 4'h1;
      end
      s_d.ir_prev_bit = tx_serial_bit;
      ir_pulse = ~tx_serial_bit & (s_q.ir_tx_cnt < uart_mls_pkg::IR_PULSE_TICKS);

      // Infrared decoder: pulse stretched to one bit time
      ir_in = s_q.feature_control[uart_mls_pkg::FC_IR_RX_HIGH] ? ser_rx_pin : ~ser_rx_pin;
      if (ir_in) begin
         s_d.ir_rx_cnt = uart_mls_pkg::IR_BIT_LAST;
      end else if (baud16_tick && s_q.ir_rx_cnt != 4'h0) begin
         s_d.ir_rx_cnt = s_q.ir_rx_cnt - 4'h1;
      end
      ir_dec = ~(ir_in | (s_q.ir_rx_cnt != 4'h0));

      // Serial routing
      if (loop) begin
         s_d.rx_serial = tx_serial_bit; // [RQ25]
         s_d.tx_pin = 1'b1; // [RQ25]
      end else if (s_q.modem_control[uart_mls_pkg::MC_IR_EN]) begin
         s_d.rx_serial = ir_dec; // [RQ7]
         s_d.tx_pin = ir_pulse; // [RQ7]
      end else begin
         s_d.rx_serial = ser_rx_pin;
         s_d.tx_pin = tx_serial_bit;
      end

      // Modem output pins, held inactive in loopback
      if (loop) begin
         s_d.mout = 3'b111;                                   // [RQ5] [RQ25]
      end else begin
         if (s_q.enhanced_feature_control[uart_mls_pkg::EF_AUTO_RTS]) begin
            s_d.mout.rts_n = (s_d.count >= uart_mls_pkg::RTS_HALT_LEVEL); // [RQ2]
         end else begin
            s_d.mout.rts_n = ~s_q.modem_control[uart_mls_pkg::MC_RTS];   // [RQ1]
         end
         s_d.mout.dtr_n = ~s_q.modem_control[uart_mls_pkg::MC_DTR];      // [RQ23]
         case (s_q.alternate_function[2:1])
            uart_mls_pkg::MF_AUX2: begin
               s_d.mout.multifunction_pin_n =
                  ~s_q.modem_control[uart_mls_pkg::MC_AUX2];             // [RQ4]
            end
            uart_mls_pkg::MF_BAUD: begin
               s_d.mout.multifunction_pin_n = ~s_d.baud_tick;
            end
            uart_mls_pkg::MF_RX_READY: begin
               s_d.mout.multifunction_pin_n = (s_d.count == 5'h00);
            end
            default: begin
               s_d.mout.multifunction_pin_n = 1'b1;
            end
         endcase
      end

      // Synchronous reset values
      if (sys_rst) begin
         s_d = '0;
         s_d.ready = 1'b1;
         s_d.holding_empty = 1'b1;
         s_d.modem_control = uart_mls_pkg::CTRL_RESET;        // [RQ5] [RQ8]
         s_d.scratch_pad = uart_mls_pkg::SCRATCH_RESET;       // [RQ21]
         s_d.tx_pin = 1'b1;
         s_d.rx_serial = 1'b1;
         s_d.ir_prev_bit = 1'b1;
         s_d.mout = 3'b111;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      s_q <= s_d;
   end

endmodule : uart_modem_line_status

//--- test/uart_mls_chk.sv
`timescale 1ns/1ps
module uart_mls_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Transmit and pins
   input wire logic tx_shift_busy,
   input wire logic tx_load,
   input wire logic [7:0] tx_byte,
   input wire logic baud_src_tick,
   input wire logic ser_tx_pin,
   input wire uart_mls_pkg::modem_out_t modem_out
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   // One wait state per taken transfer
   bus_wait_a: assert property (hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
      else $error("bus wait state wrong");
   hresp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   rst_idle_a: assert property (!sys_rst && $past(sys_rst) |-> hreadyout && !tx_load && ser_tx_pin && modem_out == 3'h7)
      else $error("outputs not idle after reset");
   load_pulse_a: assert property (tx_load |=> !tx_load)
      else $error("load pulse too long");
   load_idle_a: assert property (tx_load |-> !$past(tx_shift_busy))
      else $error("load while shifter busy");
   byte_hold_a: assert property (!tx_load |-> $stable(tx_byte))
      else $error("byte changed without load");
   baud_div_a: assert property ($fell(baud_src_tick) |-> ##[1:3] baud_src_tick)
      else $error("baud enable gap too long");
   rd_upper_a: assert property (hrdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   // Main scenarios
   load_c: cover property (tx_load);
   wait_c: cover property (!hreadyout);
   div_c: cover property ($fell(baud_src_tick));
endmodule : uart_mls_chk

bind uart_modem_line_status uart_mls_chk i_uart_mls_chk (
   .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_shift_busy(tx_shift_busy),
   .tx_load(tx_load), .tx_byte(tx_byte), .baud_src_tick(baud_src_tick),
   .ser_tx_pin(ser_tx_pin), .modem_out(modem_out));

//--- test/uart_mls_partner.sv
`timescale 1ns/1ps
module uart_mls_partner #(parameter int BUSY = 20) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Transmitter engine
   input wire logic tx_load,
   input wire logic [7:0] tx_byte,
   output logic tx_shift_busy,
   output logic tx_serial_bit,
   output logic baud16_tick,
   // Modem line levels
   input wire logic [3:0] pins_set,
   output uart_mls_pkg::modem_in_t modem_in
);
   logic [7:0] cnt_q;
   logic [9:0] frame_q;
   logic [1:0] div_q;
   // Shifter busy for a whole frame, one bit per two cycles
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_q <= '0;
         frame_q <= '1;
         div_q <= '0;
      end else begin
         div_q <= div_q + 2'h1;
         if (tx_load) begin
            cnt_q <= 8'(BUSY);
            frame_q <= {1'b1, tx_byte, 1'b0};
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q[0]) frame_q <= {1'b1, frame_q[9:1]};
         end
      end
   end
   // Busy rises the cycle after the load
   assign tx_shift_busy = cnt_q != 8'h00;
   assign tx_serial_bit = frame_q[0];
   assign baud16_tick = div_q == 2'h3;
   assign modem_in = pins_set;
endmodule : uart_mls_partner

//--- test/tb_uart_modem_line_status.sv
`timescale 1ns/1ps
module tb_uart_modem_line_status;
   localparam logic [31:0] A_HO = uart_mls_pkg::OFS_HOLDING, A_IE = uart_mls_pkg::OFS_INT_ENABLE;
   localparam logic [31:0] A_MC = uart_mls_pkg::OFS_MODEM_CONTROL, A_FC = uart_mls_pkg::OFS_FEATURE_CONTROL;
   localparam logic [31:0] A_LS = uart_mls_pkg::OFS_LINE_STATUS, A_MS = uart_mls_pkg::OFS_MODEM_STATUS;
   localparam logic [31:0] A_SP = uart_mls_pkg::OFS_SCRATCH_PAD, A_EF = uart_mls_pkg::OFS_ENH_FEATURE;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] haddr = '0, hwdata = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0, rx_valid = 1'b0;
   uart_mls_pkg::rx_char_t rx_char = '0;
   logic [3:0] pins = 4'hF;
   logic [31:0] hrdata, v, cnt;
   logic hreadyout, tx_shift_busy, tx_serial_bit, tx_load, baud16_tick;
   logic baud_src_tick, ser_tx_pin, modem_irq;
   logic [7:0] tx_byte;
   uart_mls_pkg::modem_in_t modem_in;
   uart_mls_pkg::modem_out_t modem_out;
   int bad_count = 0, samples_checked = 0, n;
   uart_modem_line_status i_uart_modem_line_status (
      .mclk(mclk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .rx_valid(rx_valid), .rx_char(rx_char),
      .rx_serial(), .tx_shift_busy(tx_shift_busy), .tx_serial_bit(tx_serial_bit),
      .tx_load(tx_load), .tx_byte(tx_byte), .baud16_tick(baud16_tick),
      .baud_src_tick(baud_src_tick), .ser_rx_pin(1'b1), .ser_tx_pin(ser_tx_pin),
      .modem_in(modem_in), .modem_out(modem_out), .modem_irq(modem_irq));
   uart_mls_partner i_uart_mls_partner (.mclk(mclk), .sys_rst(sys_rst), .tx_load(tx_load),
      .tx_byte(tx_byte), .tx_shift_busy(tx_shift_busy), .tx_serial_bit(tx_serial_bit),
      .baud16_tick(baud16_tick), .pins_set(pins), .modem_in(modem_in));
   initial forever #10 mclk = ~mclk;
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   // Bounded wait: a hang is counted and ends the run
   task automatic step;
      @(posedge mclk);
      n++;
      if (n > 99) begin
         bad_count++;
         $display("Error at %0t: wait timed out", $time);
         tally_and_finish;
      end
   endtask : step
   // Address phase held until ready, then data phase until ready
   task automatic bus(input logic w, input logic [31:0] a, d);
      n = 0;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do step; while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do step; while (hreadyout !== 1'b1);
      v = hrdata;
   endtask : bus
   task automatic rd(input logic [31:0] a, e);
      bus(1'b0, a, '0);
      chk(v, e);
   endtask : rd
   // Back to back characters, valid held across them
   task automatic push(input int cnt_chars, input logic [7:0] d0, input logic [2:0] e);
      rx_valid <= 1'b1;
      for (int i = 0; i < cnt_chars; i++) begin
         rx_char <= {d0 + 8'(i), e};
         @(posedge mclk);
      end
      rx_valid <= 1'b0;
      @(posedge mclk);
   endtask : push
   initial begin
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rd(A_SP, 32'h0000_00FF);
      rd(A_MC, 32'h0000_0000);
      rd(A_LS, 32'h0000_0060);
      rd(A_MS, 32'h0000_0000);
      chk(modem_out, 3'h7);
      rd(32'h0000_0100, 32'h0000_0000);
      bus(1'b1, A_MC, 32'h0000_000B);
      repeat (2) @(posedge mclk);
      chk(modem_out, 3'h0);
      bus(1'b1, A_MC, 32'h0000_001F);
      repeat (2) @(posedge mclk);
      chk(modem_out, 3'h7);
      bus(1'b0, A_MS, '0);
      chk(v[7:4], 4'hF);
      bus(1'b1, A_MC, 32'h0000_0000);
      repeat (3) @(posedge mclk);
      bus(1'b0, A_MS, '0);
      rd(A_MS, 32'h0000_0000);
      $display("Test modem control done");
      bus(1'b1, A_IE, 32'h0000_0008);
      pins <= 4'hE;
      repeat (4) @(posedge mclk);
      chk(modem_irq, 1'b1);
      rd(A_MS, 32'h0000_0011);
      rd(A_MS, 32'h0000_0010);
      chk(modem_irq, 1'b0);
      pins <= 4'hA;
      repeat (4) @(posedge mclk);
      rd(A_MS, 32'h0000_0050);
      pins <= 4'hE;
      repeat (4) @(posedge mclk);
      rd(A_MS, 32'h0000_0014);
      $display("Test modem status done");
      // Parity, framing and break marks in turn
      for (int k = 0; k < 3; k++) begin
         push(1, 8'h3C, 3'h4 >> k);
         rd(A_LS, 32'h0000_00E1 | (32'h0000_0004 << k));
         rd(A_HO, 32'h0000_003C);
      end
      rd(A_LS, 32'h0000_0060);
      bus(1'b1, A_EF, 32'h0000_0040);
      bus(1'b1, A_MC, 32'h0000_0002);
      chk(modem_out.rts_n, 1'b0);
      push(17, 8'h40, 3'h0);
      chk(modem_out.rts_n, 1'b1);
      rd(A_LS, 32'h0000_0063);
      rd(A_LS, 32'h0000_0061);
      for (int k = 0; k < 16; k++) rd(A_HO, 32'h0000_0040 + k);
      rd(A_LS, 32'h0000_0060);
      chk(modem_out.rts_n, 1'b0);
      $display("Test receive done");
      bus(1'b1, A_HO, 32'h0000_00A5);
      rd(A_LS, 32'h0000_0020);
      chk(tx_byte, 8'hA5);
      n = 0;
      while (tx_shift_busy !== 1'b0) step;
      rd(A_LS, 32'h0000_0060);
      bus(1'b1, A_MC, 32'h0000_0040);
      repeat (4) @(posedge mclk);
      chk(ser_tx_pin, 1'b0);
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, A_MC, k ? 32'h0000_0080 : 32'h0000_0000);
         cnt = '0;
         repeat (8) begin
            @(posedge mclk);
            cnt = cnt + baud_src_tick;
         end
         chk(cnt, k ? 32'h0000_0002 : 32'h0000_0008);
      end
      $display("Test transmit done");
      bus(1'b1, A_SP, 32'h0000_005A);
      rd(A_SP, 32'h0000_005A);
      bus(1'b1, A_FC, 32'h0000_0040);
      bus(1'b1, A_SP, 32'h0000_0033);
      bus(1'b1, A_FC, 32'h0000_0000);
      bus(1'b1, 32'h0000_0100, 32'h0000_0077);
      rd(A_SP, 32'h0000_005A);
      $display("Test scratch done");
      tally_and_finish;
   end
endmodule : tb_uart_modem_line_status
